// file: ctrl_model.sv
`timescale 1ns/1ps
`include "sram_defs.svh"
// Bus master side: presents the write word for the edge two issues after the write
module ctrl_model
	import sram_pkg::*;
(
	input wire logic clk,
	input wire logic hold,
	input wire logic wbeat,
	input wire word_t wdata,
	output logic [`DATA_W-1:0] data_lines_in,
	output lanes_t parity_lines_in
);
	logic stage_wr = 1'b0;
	word_t stage_data = 36'h0;
	word_t bus = 36'h0;
	////////////////////////////////////////
	// Off-slot the bus toggles, so a stale word is never written by accident
	always @(posedge clk) begin
		if (!hold) begin
			stage_wr <= wbeat;
			stage_data <= wdata;
			bus <= stage_wr ? stage_data : ~bus;
		end
	end
	// Lane i carries parity bit i above data byte i
	always_comb begin
		for (int i = 0; i < `LANES; i++) begin
			data_lines_in[8*i +: 8] = bus[9*i +: 8];
			parity_lines_in[i] = bus[9*i+8];
		end
	end
endmodule : ctrl_model

// file: pair_buffer.sv
`timescale 1ns/1ps
`include "sram_defs.svh"
module pair_buffer (
	input wire logic clk,
	input wire logic reset_n,
	stream_if.dst fill,
	stream_if.src drain
);
	import sram_pkg::*;

	word_t slot [0:1];
	logic [1:0] count;
	logic head;
	logic push;
	logic pop;

	////////////////////////////////////////////////////////////////////////////
	// Ready depends on the count alone, so no loop forms through the stall
	assign fill.ready = (count != `BUF_DEPTH);
	assign drain.valid = (count != `BUF_EMPTY);
	assign drain.data = slot[head];
	assign push = fill.valid && fill.ready;
	assign pop = drain.valid && drain.ready;

	// Occupancy
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			count <= `BUF_EMPTY;
		end else if (push && !pop) begin
			count <= count + 2'h1;
		end else if (pop && !push) begin
			count <= count - 2'h1;
		end
	end

	// Head pointer; tail is head plus count, modulo two
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			head <= `BUF_PTR_RESET;
		end else if (pop) begin
			head <= ~head;
		end
	end

	// Slot storage
	always_ff @(posedge clk) begin
		if (push) begin
			slot[head ^ count[0]] <= fill.data;
		end
	end
endmodule : pair_buffer

// file: pipelined_sync_sram.sv
`timescale 1ns/1ps
`include "sram_defs.svh"
// Function
// - Data cycle two edges after address edge
// - Inputs registered on rising clock edge
// - Reads and writes follow back to back
// - Output enable disables outputs asynchronously
// - Output drive follows read cycles internally
// - Clock gate high freezes pipeline, burst and array state; the read stream still drains
// - Deselected load starts no new operation
// - Issued transfers finish despite later deselect
// - Bus released two cycles after deselect/write
// - One address yields four burst beats
// - Order input picks linear or interleaved
// - Address captured only on selected load
// - Deselected load ends any running burst
// - Advance steps burst, ignores address lines
// - Read/write select decides each loaded access
// - Array is 256K words of 36 bits
// - Per-lane byte write control
// - High order input means interleaved, static
// - Lane enables per beat, two cycles later
// - Sleep gates clock and keeps contents
// - Three selects, one active high, all needed
module pipelined_sync_sram (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clock_gate_low,
	input wire logic advance_or_load,
	input wire logic read_write,
	input wire logic select_low_a,
	input wire logic select_high,
	input wire logic select_low_b,
	input wire sram_pkg::addr_t address_lines,
	input wire sram_pkg::lanes_t byte_write_lanes_n,
	input wire logic burst_order_select,
	input wire logic output_enable_n,
	input wire logic sleep_request,
	input wire logic [`DATA_W-1:0] data_lines_in,
	input wire sram_pkg::lanes_t parity_lines_in,
	output logic [`DATA_W-1:0] data_lines_out,
	output sram_pkg::lanes_t parity_lines_out,
	output logic data_lines_oe,
	output sram_pkg::word_t read_word,
	output logic read_valid,
	input wire logic read_ready,
	output logic suspended
);
	import sram_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Helpers

	// Next beat address; upper bits never move so the burst wraps in a group of four
	function automatic addr_t beat_addr(addr_t base, beat_t beat, logic interleave);
		beat_t lsb;
		lsb = interleave ? (base[`BURST_W-1:0] ^ beat) : beat_t'(base[`BURST_W-1:0] + beat);
		return {base[`ADDR_W-1:`BURST_W], lsb};
	endfunction : beat_addr

	// Lane i is parity bit i over data byte i
	function automatic word_t pack_lanes(logic [`DATA_W-1:0] data, lanes_t parity);
		word_t w;
		w = `WORD_RESET;
		for (int i = 0; i < `LANES; i++) begin
			w[i*`LANE_W +: `LANE_W] = {parity[i], data[i*`BYTE_W +: `BYTE_W]};
		end
		return w;
	endfunction : pack_lanes

	////////////////////////////////////////////////////////////////////////////
	// Signals

	mem_if mport();
	stream_if rstream();
	stream_if ostream();

	logic stall;
	logic selected;
	logic load;
	stage_t next_stage;
	stage_t stage_a;
	stage_t stage_b;
	op_t burst_op;
	addr_t burst_base;
	beat_t burst_count;
	addr_t next_beat;
	beat_t next_lsb;
	logic drive;
	logic rd_fresh;

	////////////////////////////////////////////////////////////////////////////
	// Input decode

	// Sleep and a full read buffer act like a held clock gate, so nothing is lost
	assign stall = clock_gate_low | sleep_request | ~rstream.ready;
	assign suspended = stall;
	// All three selects must be asserted; the middle one is active high
	assign selected = ~select_low_a & select_high & ~select_low_b;
	assign load = ~advance_or_load;
	// A function result cannot be sliced directly, so the beat address gets its own net
	assign next_beat = beat_addr(burst_base, beat_t'(burst_count + `BURST_STEP),
		burst_order_select);
	assign next_lsb = next_beat[`BURST_W-1:0];

	// Next first-stage contents; lane enables are taken on every beat
	always_comb begin
		next_stage.op = OP_IDLE;
		next_stage.addr = stage_a.addr;
		next_stage.bw_n = byte_write_lanes_n;
		if (load) begin
			if (selected) begin
				next_stage.op = (read_write == `RW_READ) ? OP_READ : OP_WRITE;
				next_stage.addr = address_lines;
			end
		end else if (burst_op != OP_IDLE) begin
			// External address ignored while advancing
			next_stage.op = burst_op;
			next_stage.addr = next_beat;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Burst counter

	// A deselected load ends the burst; an advance with no burst issues nothing
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			burst_op <= OP_IDLE;
			burst_base <= `ADDR_RESET;
			burst_count <= `BURST_FIRST;
		end else if (!stall) begin
			if (load) begin
				if (selected) begin
					burst_op <= (read_write == `RW_READ) ? OP_READ : OP_WRITE;
					burst_base <= address_lines;
					burst_count <= `BURST_FIRST;
				end else begin
					burst_op <= OP_IDLE;
				end
			end else if (burst_op != OP_IDLE) begin
				burst_count <= beat_t'(burst_count + `BURST_STEP);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pipeline

	// First stage: registered address and control
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			stage_a <= '{op: OP_IDLE, addr: `ADDR_RESET, bw_n: `LANES_IDLE};
		end else if (!stall) begin
			stage_a <= next_stage;
		end
	end

	// Second stage carries issued work regardless of later deselects
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			stage_b <= '{op: OP_IDLE, addr: `ADDR_RESET, bw_n: `LANES_IDLE};
		end else if (!stall) begin
			stage_b <= stage_a;
		end
	end

	// Array access on the data edge; any op mix may follow with no gap
	assign mport.access = ~stall & (stage_b.op != OP_IDLE);
	assign mport.write = (stage_b.op == OP_WRITE);
	assign mport.lane_we = ~stage_b.bw_n;
	assign mport.addr = stage_b.addr;
	assign mport.wdata = pack_lanes(data_lines_in, parity_lines_in);

	word_mem u_mem (
		.clk(clk),
		.reset_n(reset_n),
		.port(mport)
	);

	////////////////////////////////////////////////////////////////////////////
	// Output drive

	// Drive only in read data cycles; writes and deselects release the bus
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			drive <= 1'h0;
		end else if (!stall) begin
			drive <= (stage_b.op == OP_READ);
		end
	end

	// Output enable gates the drive with no clock in the path
	assign data_lines_oe = drive & ~output_enable_n;

	// Lanes back onto data and parity pins, straight from the read register
	always_comb begin
		data_lines_out = '0;
		parity_lines_out = '0;
		for (int i = 0; i < `LANES; i++) begin
			data_lines_out[i*`BYTE_W +: `BYTE_W] = mport.rdata[i*`LANE_W +: `BYTE_W];
			parity_lines_out[i] = mport.rdata[i*`LANE_W + `BYTE_W];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read stream

	// A fresh read word is offered once; the set on a new read wins over the clear
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			rd_fresh <= 1'h0;
		end else if (!stall && stage_b.op == OP_READ) begin
			rd_fresh <= 1'h1;
		end else if (rstream.ready) begin
			rd_fresh <= 1'h0;
		end
	end

	assign rstream.valid = rd_fresh;
	assign rstream.data = mport.rdata;
	assign ostream.ready = read_ready;
	assign read_valid = ostream.valid;
	assign read_word = ostream.data;

	pair_buffer u_buf (
		.clk(clk),
		.reset_n(reset_n),
		.fill(rstream),
		.drain(ostream)
	);

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	chk_read_latency: assert property (
		(!stall && load && selected && read_write) ##1 !stall ##1 !stall |=> drive)
		else $error("read issued but bus not driven two cycles later");

	chk_write_access: assert property (
		(!stall && load && selected && !read_write) ##1 !stall ##1 !stall
		|-> mport.access && mport.write)
		else $error("write issued but array not written on data edge");

	chk_stall_hold: assert property (
		stall |=> $stable(stage_a) && $stable(burst_count) && $stable(drive))
		else $error("state moved while suspended");

	chk_deselect_nop: assert property (
		(!stall && load && !selected) |=> stage_a.op == OP_IDLE)
		else $error("deselected load started an operation");

	chk_bus_release: assert property (
		(!stall && load && (!selected || !read_write)) ##1 !stall ##1 !stall
		|=> !data_lines_oe)
		else $error("bus still driven two cycles after deselect or write");

	chk_async_oe: assert property (
		output_enable_n |-> !data_lines_oe)
		else $error("pins driven with output enable off");

	chk_burst_step: assert property (
		(!stall && !load && burst_op != OP_IDLE)
		|=> burst_count == beat_t'($past(burst_count) + `BURST_STEP)
		&& stage_a.addr[`ADDR_W-1:`BURST_W] == $past(burst_base[`ADDR_W-1:`BURST_W]))
		else $error("burst advance wrong");

	chk_order_lsb: assert property (
		(!stall && !load && burst_op != OP_IDLE)
		|=> stage_a.addr[`BURST_W-1:0] == $past(next_lsb))
		else $error("burst beat address not in selected order");

	chk_burst_end: assert property (
		(!stall && load && !selected) |=> burst_op == OP_IDLE)
		else $error("burst survived a deselect");

	chk_load_capture: assert property (
		(!stall && load && selected) |=> stage_a.addr == $past(address_lines)
		&& burst_count == `BURST_FIRST)
		else $error("address not captured on selected load");
endmodule : pipelined_sync_sram

// file: pipelined_sync_sram_burst_tb.sv
`timescale 1ns/1ps
`include "sram_defs.svh"
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
	$display("MISMATCH %s expected %h seen %h", nm, ex, got); err_count++; end end
module pipelined_sync_sram_burst_tb;
	import sram_pkg::*;
	logic clk = 1'b0, reset_n = 1'b0, clock_gate_low = 1'b0, advance_or_load = 1'b0;
	logic read_write = 1'b1, select_low_a = 1'b1, select_high = 1'b0, select_low_b = 1'b1;
	logic burst_order_select = 1'b0, output_enable_n = 1'b0, sleep_request = 1'b0;
	logic read_ready = 1'b1, wbeat = 1'b0;
	addr_t address_lines = 18'h0;
	lanes_t byte_write_lanes_n = 4'hf;
	word_t wdata = 36'h0;
	logic [`DATA_W-1:0] data_lines_in, data_lines_out;
	lanes_t parity_lines_in, parity_lines_out;
	logic data_lines_oe, read_valid, suspended;
	word_t read_word;
	word_t mem[addr_t];
	word_t exp_q[$];
	int err_count = 0, cmp_count = 0, n = 0, k1 = 0, k2 = 0;
	bit stall = 1'b0, cur_wr = 1'b0, run = 1'b0, rd = 1'b0;
	addr_t base, a1, a2;
	lanes_t l1, l2;
	pipelined_sync_sram dut_u (.clk(clk), .reset_n(reset_n), .clock_gate_low(clock_gate_low),
		.advance_or_load(advance_or_load), .read_write(read_write),
		.select_low_a(select_low_a), .select_high(select_high), .select_low_b(select_low_b),
		.address_lines(address_lines), .byte_write_lanes_n(byte_write_lanes_n),
		.burst_order_select(burst_order_select), .output_enable_n(output_enable_n),
		.sleep_request(sleep_request), .data_lines_in(data_lines_in),
		.parity_lines_in(parity_lines_in), .data_lines_out(data_lines_out),
		.parity_lines_out(parity_lines_out), .data_lines_oe(data_lines_oe),
		.read_word(read_word), .read_valid(read_valid), .read_ready(read_ready),
		.suspended(suspended));
	ctrl_model partner_u (.clk(clk), .hold(suspended), .wbeat(wbeat), .wdata(wdata),
		.data_lines_in(data_lines_in), .parity_lines_in(parity_lines_in));
	////////////////////////////////////////
	// Free-running 100 MHz clock
	initial begin
		forever #5 clk = ~clk;
	end
	function automatic word_t lanes_join(input logic [`DATA_W-1:0] d, input lanes_t p);
		word_t w;
		for (int i = 0; i < `LANES; i++) w[9*i +: 9] = {p[i], d[8*i +: 8]};
		return w;
	endfunction : lanes_join
	task automatic results;
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : results
	////////////////////////////////////////
	// Reference: issue pipe counted in unsuspended edges, array and read stream
	always @(posedge clk) begin : ref_model
		word_t w, win;
		bit pin_rd;
		pin_rd = 1'b0;
		if (reset_n && read_valid && read_ready) begin
			w = exp_q.size() ? exp_q.pop_front() : 'x;
			`CHK("read_word", w, read_word)
		end
		if (!reset_n) begin
			run = 1'b0;
			k1 = 0;
			k2 = 0;
			exp_q.delete();
		end else if (!suspended) begin
			win = lanes_join(data_lines_in, parity_lines_in);
			w = mem.exists(a2) ? mem[a2] : 'x;
			if (k2 == 2) begin
				for (int i = 0; i < `LANES; i++) if (!l2[i]) w[9*i +: 9] = win[9*i +: 9];
				mem[a2] = w;
			end
			pin_rd = (k2 == 1);
			if (pin_rd) exp_q.push_back(w);
			k2 = k1;
			a2 = a1;
			l2 = l1;
			if (!advance_or_load) begin
				run = !select_low_a && select_high && !select_low_b;
				n = 0;
				base = address_lines;
				rd = read_write;
			end else n = n + 1;
			k1 = !run ? 0 : rd ? 1 : 2;
			a1 = base;
			a1[1:0] = burst_order_select ? base[1:0] ^ n[1:0] : base[1:0] + n[1:0];
			l1 = byte_write_lanes_n;
			#1;
			`CHK("drive", pin_rd && !output_enable_n, data_lines_oe)
			if (pin_rd) `CHK("pins", w, lanes_join(data_lines_out, parity_lines_out))
		end
	end
	////////////////////////////////////////
	// One issue edge; deselect mask bits drop select_low_a, select_high, select_low_b
	task automatic cyc(input bit adv, rw, input bit [2:0] d, input addr_t a, input lanes_t ln,
		input bit wr);
		advance_or_load <= adv;
		read_write <= rw;
		select_low_a <= d[0];
		select_high <= !d[1];
		select_low_b <= d[2];
		address_lines <= a;
		byte_write_lanes_n <= ln;
		wbeat <= wr;
		wdata <= word_t'({$urandom(), $urandom()});
		read_ready <= !stall && ($urandom() % 4 != 0);
		@(posedge clk);
	endtask : cyc
	task automatic load(input bit rw, input addr_t a, input lanes_t ln);
		cur_wr = !rw;
		cyc(1'b0, rw, 3'h0, a, ln, cur_wr);
	endtask : load
	task automatic adv(input lanes_t ln);
		cyc(1'b1, 1'b0, 3'h0, addr_t'($urandom()), ln, cur_wr);
	endtask : adv
	task automatic idle;
		cur_wr = 1'b0;
		cyc(1'b0, 1'b1, 3'h1, addr_t'($urandom()), 4'hf, 1'b0);
	endtask : idle
	// Watchdog
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		results();
	end
	////////////////////////////////////////
	// Main sequence, once per burst order with a reset between
	initial begin
		addr_t b;
		void'($urandom(16));
		for (int o = 0; o < 2; o++) begin
			reset_n <= 1'b0;
			burst_order_select <= o[0];
			repeat (8) @(posedge clk);
			reset_n <= 1'b1;
			b = addr_t'($urandom());
			load(1'b0, b, 4'h0);
			repeat (3) adv(4'h0);
			load(1'b1, b, 4'h0);
			adv(4'h0);
			clock_gate_low <= 1'b1;
			repeat (2) @(posedge clk);
			clock_gate_low <= 1'b0;
			repeat (3) adv(4'h0);
			load(1'b0, b, lanes_t'($urandom()));
			adv(lanes_t'($urandom()));
			for (int i = 0; i < 3; i++) begin
				cyc(1'b0, 1'b0, 3'h1 << i, addr_t'($urandom()), 4'h0, 1'b0);
				adv(4'h0);
			end
			load(1'b1, b, 4'h0);
			adv(4'h0);
			@(posedge clk);
			#3 output_enable_n = 1'b1;
			#1 `CHK("drive_async", 1'b0, data_lines_oe)
			@(posedge clk);
			output_enable_n <= 1'b0;
			sleep_request <= 1'b1;
			repeat (2) @(posedge clk);
			sleep_request <= 1'b0;
			repeat (3) adv(4'h0);
			stall = 1'b1;
			load(1'b1, b, 4'h0);
			repeat (3) adv(4'h0);
			repeat (4) idle();
			`CHK("stall", 1'b1, suspended)
			stall = 1'b0;
			for (int i = 0; i < 60 && (exp_q.size() != 0 || read_valid !== 1'b0); i++) idle();
			if (exp_q.size() != 0) err_count++;
		end
		results();
	end
endmodule : pipelined_sync_sram_burst_tb

// file: sram_defs.svh
`ifndef SRAM_DEFS_SVH
`define SRAM_DEFS_SVH
// Array organisation: 256K words of four 9-bit lanes
`define ADDR_W 18
`define WORD_W 36
`define LANES 4
`define LANE_W 9
`define BYTE_W 8
`define DATA_W 32
// Burst counter touches only the low address bits
`define BURST_W 2
`define BURST_STEP 2'h1
`define BURST_FIRST 2'h0
// Read data stream buffer
`define BUF_DEPTH 2'h2
`define BUF_EMPTY 2'h0
`define BUF_PTR_RESET 1'h0
// Level of the read/write select that asks for a read
`define RW_READ 1'h1
`define WORD_RESET 36'h0
`define ADDR_RESET 18'h0
`define LANES_IDLE 4'hf
`endif

// file: sram_if.sv
`timescale 1ns/1ps
`include "sram_defs.svh"
// Array access port: one access per edge, lane write enables active high
interface mem_if;
	import sram_pkg::*;
	logic access;
	logic write;
	lanes_t lane_we;
	addr_t addr;
	word_t wdata;
	word_t rdata;
	modport ctrl(output access, output write, output lane_we, output addr, output wdata,
		input rdata);
	modport mem(input access, input write, input lane_we, input addr, input wdata,
		output rdata);
endinterface : mem_if

// Word stream with valid and ready
interface stream_if;
	import sram_pkg::*;
	word_t data;
	logic valid;
	logic ready;
	modport src(output data, output valid, input ready);
	modport dst(input data, input valid, output ready);
endinterface : stream_if

// file: sram_pkg.sv
`include "sram_defs.svh"
package sram_pkg;
	typedef logic [`ADDR_W-1:0] addr_t;
	typedef logic [`WORD_W-1:0] word_t;
	typedef logic [`LANES-1:0] lanes_t;
	typedef logic [`BURST_W-1:0] beat_t;
	typedef enum logic [1:0] {
		OP_IDLE = 2'h0,
		OP_READ = 2'h1,
		OP_WRITE = 2'h2
	} op_t;
	typedef struct packed {
		op_t op;
		addr_t addr;
		lanes_t bw_n;
	} stage_t;
endpackage : sram_pkg

// file: word_mem.sv
`timescale 1ns/1ps
`include "sram_defs.svh"
module word_mem (
	input wire logic clk,
	input wire logic reset_n,
	mem_if.mem port
);
	import sram_pkg::*;

	word_t cells [0:(1 << `ADDR_W) - 1];

	////////////////////////////////////////////////////////////////////////////
	// Lane-wise write; a lane whose enable is low keeps its old contents
	always_ff @(posedge clk) begin
		if (port.access && port.write) begin
			for (int i = 0; i < `LANES; i++) begin
				if (port.lane_we[i]) begin
					cells[port.addr][i*`LANE_W +: `LANE_W] <= port.wdata[i*`LANE_W +: `LANE_W];
				end
			end
		end
	end

	// Registered read; holds its word between reads so the pins stay steady
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			port.rdata <= `WORD_RESET;
		end else if (port.access && !port.write) begin
			port.rdata <= cells[port.addr];
		end
	end
endmodule : word_mem
